// ---- bench/smm_pin_watch.sv ----
// far side model: board logic counting rising edges on one status pin
`timescale 1ns/1ns
module smm_pin_watch (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // watched pin and edge count
  input wire logic pin_i,
  output logic [7:0] rise_count_o
);
  logic last_q;
  // pin is registered in the device, so sampling on the same clock is safe
  always_ff @(posedge clock_i) begin
    last_q <= pin_i;
    if (srst_i) begin
      rise_count_o <= 8'h00;
    end else if (pin_i && !last_q) begin
      rise_count_o <= rise_count_o + 8'h01;
    end
  end
endmodule

// ---- bench/tb_status_monitor_mux.sv ----
// self-checking bench for the status monitor mux
`timescale 1ns/1ns
`include "smm_cfg.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_status_monitor_mux;
  logic clock_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [9:0] reg_addr_i = 10'h000;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, c0, c1;
  logic [8:0] f = 9'h000;
  logic [3:0] dyn = 4'h0;
  logic pin0, pin1, hold;
  int fail_count = 0, n_tests = 0;
  // ************************************************************
  // rows: code, flags {oref,fb,osc,tst,sec,pri,secsel,olock,ilock}, pin
  // ************************************************************
  logic [15:0] rows [0:36] = '{
    {6'h00,9'h1ff,1'b0}, {6'h01,9'h1ff,1'b1}, {6'h01,9'h001,1'b0}, {6'h02,9'h001,1'b1},
    {6'h02,9'h1fe,1'b0}, {6'h03,9'h002,1'b1}, {6'h03,9'h1fd,1'b0}, {6'h04,9'h000,1'b1},
    {6'h04,9'h008,1'b0}, {6'h05,9'h002,1'b1}, {6'h05,9'h000,1'b0}, {6'h06,9'h004,1'b1},
    {6'h06,9'h1fb,1'b0}, {6'h07,9'h008,1'b1}, {6'h07,9'h1f7,1'b0}, {6'h08,9'h010,1'b1},
    {6'h08,9'h1ef,1'b0}, {6'h09,9'h020,1'b1}, {6'h09,9'h1df,1'b0}, {6'h0a,9'h040,1'b1},
    {6'h0a,9'h1bf,1'b0}, {6'h0b,9'h080,1'b1}, {6'h0b,9'h17f,1'b0}, {6'h0c,9'h100,1'b1},
    {6'h0c,9'h0ff,1'b0}, {6'h0d,9'h1ff,1'b0}, {6'h0e,9'h018,1'b1}, {6'h0e,9'h010,1'b0},
    {6'h0f,9'h1d8,1'b1}, {6'h0f,9'h1ff,1'b1}, {6'h0f,9'h1d0,1'b0}, {6'h14,9'h1ff,1'b0},
    {6'h15,9'h1ff,1'b0}, {6'h17,9'h1ff,1'b0}, {6'h18,9'h1ff,1'b0}, {6'h20,9'h1ff,1'b0},
    {6'h3f,9'h1ff,1'b0}};

  always #5 clock_i = ~clock_i;

  smm_status_mux smm_status_mux_inst (
    .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .input_loop_lock_i(f[0]), .output_loop_lock_i(f[1]),
    .secondary_reference_selected_i(f[2]), .primary_reference_ok_i(f[3]),
    .secondary_reference_ok_i(f[4]), .test_reference_ok_i(f[5]),
    .cleanup_oscillator_ok_i(f[6]), .input_loop_feedback_ok_i(f[7]),
    .output_loop_reference_ok_i(f[8]), .input_loop_feedback_clk_i(dyn[0]),
    .input_loop_pfd_down_i(dyn[1]), .input_loop_reference_clk_i(dyn[2]),
    .input_loop_pfd_up_i(dyn[3]), .first_status_pin_o(pin0),
    .second_status_pin_o(pin1), .holdover_o(hold));
  smm_pin_watch smm_pin_watch_inst (
    .clock_i(clock_i), .srst_i(srst_i), .pin_i(pin0), .rise_count_o(c0));
  smm_pin_watch smm_pin_watch_inst1 (
    .clock_i(clock_i), .srst_i(srst_i), .pin_i(pin1), .rise_count_o(c1));

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    step(1);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] ex);
    step(1);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    step(1);
    reg_rd_i = 1'b0;
    step(1);
    `CHK("read data", ex, reg_rdata_o)
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] b0, b1;
    step(4);
    srst_i = 1'b0;
    `CHK("pin0 after reset", 1'b0, pin0)
    rd(`SMM_OFS_SEL0, 8'h00);
    // ************************************************************
    // ordinary cases
    // ************************************************************
    foreach (rows[i]) begin
      f = rows[i][9:1];
      wr(`SMM_OFS_SEL0, {2'b00, rows[i][15:10]});
      wr(`SMM_OFS_SEL1, {2'b00, rows[i][15:10]});
      step(10);
      `CHK("first pin", rows[i][0], pin0)
      `CHK("second pin", rows[i][0], pin1)
      `CHK("holdover", !f[3] && !f[4], hold)
    end
    // ************************************************************
    // reserved bits, unmapped place, back-to-back access
    // ************************************************************
    wr(`SMM_OFS_SEL0, 8'hff);
    rd(`SMM_OFS_SEL0, 8'h3f);
    wr(`SMM_OFS_SEL1, 8'hc5);
    rd(`SMM_OFS_SEL1, 8'h05);
    wr(10'h232, 8'h07);
    rd(10'h232, 8'h00);
    rd(`SMM_OFS_SEL0, 8'h3f);
    // ************************************************************
    // divided dynamic signals: 16 input rises give 8 pin rises
    // ************************************************************
    for (int i = 0; i < 4; i++) begin
      wr(`SMM_OFS_SEL0, 8'h10 + 8'(i));
      wr(`SMM_OFS_SEL1, 8'h10 + 8'(i));
      step(10);
      b0 = c0;
      b1 = c1;
      // hold each level 3 cycles, above the 2-cycle minimum
      repeat (16) begin
        dyn[i] = 1'b1;
        step(3);
        dyn[i] = 1'b0;
        step(3);
      end
      step(10);
      `CHK("first pin div rises", 8'h08, c0 - b0)
      `CHK("second pin div rises", 8'h08, c1 - b1)
    end
    // ************************************************************
    // reset in mid-run clears selects and pins
    // ************************************************************
    f = 9'h1ff;
    wr(`SMM_OFS_SEL0, 8'h01);
    wr(`SMM_OFS_SEL1, 8'h0f);
    step(10);
    `CHK("first pin before reset", 1'b1, pin0)
    `CHK("second pin before reset", 1'b1, pin1)
    srst_i = 1'b1;
    step(1);
    srst_i = 1'b0;
    `CHK("first pin after reset", 1'b0, pin0)
    `CHK("second pin after reset", 1'b0, pin1)
    rd(`SMM_OFS_SEL1, 8'h00);
    close_out();
  end
endmodule

// ---- hw/smm_status_mux.sv ----
// status monitor mux: two select bytes steering two status pins
`timescale 1ns/1ns
`include "smm_cfg.svh"
// What this block does
// - first pin select from 0x230 bits 5:0
// - second pin select 0x231, same encoding
// - codes 1-3: both locks, input, output lock
// - code 4: both references missing
// - code 5: both missing and output lock
// - code 6: secondary reference selected
// - codes 7-12: individual clock health flags
// - code 13 reserved; 14: both references healthy
// - code 15: all health except test
// - codes 16,18: loop clocks divided by two
// - codes 17,19: detector pulses divided by two
// - health flag high means clock present
// - both references missing means holdover
module smm_status_mux (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // register port from the serial control port
  input wire logic [`SMM_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // loop lock and reference state
  input wire logic input_loop_lock_i,
  input wire logic output_loop_lock_i,
  input wire logic secondary_reference_selected_i,
  // clock health, high while present
  input wire logic primary_reference_ok_i,
  input wire logic secondary_reference_ok_i,
  input wire logic test_reference_ok_i,
  input wire logic cleanup_oscillator_ok_i,
  input wire logic input_loop_feedback_ok_i,
  input wire logic output_loop_reference_ok_i,
  // dynamic input loop signals
  input wire logic input_loop_feedback_clk_i,
  input wire logic input_loop_reference_clk_i,
  input wire logic input_loop_pfd_down_i,
  input wire logic input_loop_pfd_up_i,
  // status pins
  output logic first_status_pin_o,
  output logic second_status_pin_o,
  output logic holdover_o
);

  // ************************************************************
  // registers
  // ************************************************************
  smm_pkg::smm_sel_t sel0_q;
  smm_pkg::smm_sel_t sel1_q;
  smm_pkg::smm_byte_t rdata_d;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sel0_q <= `SMM_SEL_RST;
    end else if (reg_wr_i && reg_addr_i == `SMM_OFS_SEL0) begin
      sel0_q <= reg_wdata_i[`SMM_SEL_MSB:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sel1_q <= `SMM_SEL_RST;
    end else if (reg_wr_i && reg_addr_i == `SMM_OFS_SEL1) begin
      sel1_q <= reg_wdata_i[`SMM_SEL_MSB:0];
    end
  end

  // reserved bits 7:6 and unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr_i)
      `SMM_OFS_SEL0: rdata_d = {2'b00, sel0_q};
      `SMM_OFS_SEL1: rdata_d = {2'b00, sel1_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [`SMM_NFLAG-1:0] raw;
  logic [`SMM_NFLAG-1:0] s1_q;
  logic [`SMM_NFLAG-1:0] s2_q;
  logic [`SMM_NFLAG-1:0] s3_q;
  logic [`SMM_NFLAG-1:0] flt_q;
  logic [`SMM_NFLAG-1:0] flt_prev_q;

  assign raw = {input_loop_pfd_up_i, input_loop_reference_clk_i, input_loop_pfd_down_i,
                input_loop_feedback_clk_i, secondary_reference_selected_i,
                output_loop_reference_ok_i, input_loop_feedback_ok_i,
                cleanup_oscillator_ok_i, test_reference_ok_i, secondary_reference_ok_i,
                primary_reference_ok_i, output_loop_lock_i, input_loop_lock_i};

  // a flag only moves once two stages agree, so a metastable sample never
  // reaches the mux and a one-cycle input glitch cannot reach a pin
  genvar gi;
  generate
    for (gi = 0; gi < `SMM_NFLAG; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          flt_q[gi] <= 1'b0;
          flt_prev_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
          flt_prev_q[gi] <= flt_q[gi];
        end
      end
    end
  endgenerate

  // ************************************************************
  // divide-by-two of the dynamic signals
  // ************************************************************
  // limitation: signals faster than a quarter of clock_i alias
  logic fb_div_q;
  logic dn_div_q;
  logic ref_div_q;
  logic up_div_q;
  logic [`SMM_NFLAG-1:0] rise;

  assign rise = flt_q & ~flt_prev_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fb_div_q <= 1'b0;
      ref_div_q <= 1'b0;
    end else begin
      fb_div_q <= fb_div_q ^ rise[`SMM_F_FB_CLK];
      ref_div_q <= ref_div_q ^ rise[`SMM_F_REF_CLK];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dn_div_q <= 1'b0;
      up_div_q <= 1'b0;
    end else begin
      dn_div_q <= dn_div_q ^ rise[`SMM_F_DN];
      up_div_q <= up_div_q ^ rise[`SMM_F_UP];
    end
  end

  // ************************************************************
  // combined conditions
  // ************************************************************
  logic both_lock;
  logic both_missing;
  logic refs_ok;
  logic all_ok;

  assign both_lock = flt_q[`SMM_F_IN_LOCK] & flt_q[`SMM_F_OUT_LOCK];
  // health flags are high while the clock is present
  assign both_missing = ~flt_q[`SMM_F_PRI_OK] & ~flt_q[`SMM_F_SEC_OK];
  assign refs_ok = flt_q[`SMM_F_PRI_OK] & flt_q[`SMM_F_SEC_OK];
  assign all_ok = refs_ok & flt_q[`SMM_F_OSC_OK] & flt_q[`SMM_F_FB_OK]
                  & flt_q[`SMM_F_OREF_OK];

  // ************************************************************
  // selection
  // ************************************************************
  function automatic logic pick(input smm_pkg::smm_sel_t code);
    logic v;
    v = 1'b0;
    unique case (code)
      `SMM_C_BOTH_LOCK: v = both_lock;
      `SMM_C_IN_LOCK: v = flt_q[`SMM_F_IN_LOCK];
      `SMM_C_OUT_LOCK: v = flt_q[`SMM_F_OUT_LOCK];
      `SMM_C_HOLDOVER: v = both_missing;
      `SMM_C_HOLD_LOCK: v = both_missing & flt_q[`SMM_F_OUT_LOCK];
      `SMM_C_SEC_SEL: v = flt_q[`SMM_F_SEC_SEL];
      `SMM_C_PRI_OK: v = flt_q[`SMM_F_PRI_OK];
      `SMM_C_SEC_OK: v = flt_q[`SMM_F_SEC_OK];
      `SMM_C_TST_OK: v = flt_q[`SMM_F_TST_OK];
      `SMM_C_OSC_OK: v = flt_q[`SMM_F_OSC_OK];
      `SMM_C_FB_OK: v = flt_q[`SMM_F_FB_OK];
      `SMM_C_OREF_OK: v = flt_q[`SMM_F_OREF_OK];
      `SMM_C_REFS_OK: v = refs_ok;
      `SMM_C_ALL_OK: v = all_ok;
      `SMM_C_FB_DIV: v = fb_div_q;
      `SMM_C_DN_DIV: v = dn_div_q;
      `SMM_C_REF_DIV: v = ref_div_q;
      `SMM_C_UP_DIV: v = up_div_q;
      // ground, reserved 0x0d, 0x14..0x17 and everything above
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // registered pins: a select write changes the pin on a clock edge only
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      first_status_pin_o <= 1'b0;
      second_status_pin_o <= 1'b0;
    end else begin
      first_status_pin_o <= pick(sel0_q);
      second_status_pin_o <= pick(sel1_q);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      holdover_o <= 1'b0;
    end else begin
      holdover_o <= both_missing;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  a_sel0_write: assert property (
    reg_wr_i && reg_addr_i == `SMM_OFS_SEL0 |=> sel0_q == $past(reg_wdata_i[5:0]))
    else $error("first select not written");

  a_sel1_write: assert property (
    reg_wr_i && reg_addr_i == `SMM_OFS_SEL1 |=> sel1_q == $past(reg_wdata_i[5:0]))
    else $error("second select not written");

  a_rsvd_read_zero: assert property (
    reg_rd_i |=> reg_rdata_o[7:6] == 2'b00)
    else $error("reserved bits read nonzero");

  a_lock_and: assert property (
    sel0_q == `SMM_C_BOTH_LOCK |=> first_status_pin_o ==
      $past(flt_q[`SMM_F_IN_LOCK] & flt_q[`SMM_F_OUT_LOCK]))
    else $error("both-lock code wrong");

  a_holdover_pin: assert property (
    sel1_q == `SMM_C_HOLDOVER |=> second_status_pin_o ==
      $past(!flt_q[`SMM_F_PRI_OK] && !flt_q[`SMM_F_SEC_OK]))
    else $error("holdover code wrong");

  a_hold_lock: assert property (
    sel0_q == `SMM_C_HOLD_LOCK |=> first_status_pin_o == $past(!flt_q[`SMM_F_PRI_OK]
      && !flt_q[`SMM_F_SEC_OK] && flt_q[`SMM_F_OUT_LOCK]))
    else $error("holdover-lock code wrong");

  a_pri_health: assert property (
    sel0_q == `SMM_C_PRI_OK |=> first_status_pin_o == $past(flt_q[`SMM_F_PRI_OK]))
    else $error("primary health code wrong");

  a_gnd_codes: assert property (
    sel0_q == `SMM_C_GND || sel0_q == `SMM_C_RSVD |=> !first_status_pin_o)
    else $error("ground code not low");

  a_high_codes_low: assert property (
    sel1_q > `SMM_C_UP_DIV ##1 sel1_q > `SMM_C_UP_DIV |-> !second_status_pin_o)
    else $error("upper code not low");

  a_fb_toggle: assert property (
    rise[`SMM_F_FB_CLK] |=> fb_div_q != $past(fb_div_q))
    else $error("feedback divider missed edge");

  // a reset edge clears the flag without agreement, so it is left out
  a_sync_agree: assert property (
    !$past(srst_i) && flt_q[`SMM_F_IN_LOCK] != $past(flt_q[`SMM_F_IN_LOCK]) |->
      $past(s2_q[`SMM_F_IN_LOCK]) == $past(s3_q[`SMM_F_IN_LOCK]))
    else $error("flag moved before stages agreed");

  a_sec_sel_pin: assert property (
    sel1_q == `SMM_C_SEC_SEL |=> second_status_pin_o == $past(flt_q[`SMM_F_SEC_SEL]))
    else $error("secondary-selected code wrong");

  a_refs_ok_pin: assert property (
    sel1_q == `SMM_C_REFS_OK |=> second_status_pin_o ==
      $past(flt_q[`SMM_F_PRI_OK] && flt_q[`SMM_F_SEC_OK]))
    else $error("references-ok code wrong");

  a_all_ok_pin: assert property (
    sel0_q == `SMM_C_ALL_OK |=> first_status_pin_o == $past(flt_q[`SMM_F_PRI_OK]
      && flt_q[`SMM_F_SEC_OK] && flt_q[`SMM_F_OSC_OK] && flt_q[`SMM_F_FB_OK]
      && flt_q[`SMM_F_OREF_OK]))
    else $error("all-ok code wrong");

  a_holdover_out: assert property (
    1'b1 |=> holdover_o == $past(!flt_q[`SMM_F_PRI_OK] && !flt_q[`SMM_F_SEC_OK]))
    else $error("holdover output wrong");

  a_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");

  a_dn_toggle: assert property (
    rise[`SMM_F_DN] |=> dn_div_q != $past(dn_div_q))
    else $error("down divider missed edge");

  a_same_encoding: assert property (
    sel0_q == sel1_q |=> first_status_pin_o == second_status_pin_o)
    else $error("pins differ for one code");

endmodule

// ---- shared/smm_cfg.svh ----
// offsets, field layout, reset values and select codes of the status monitor mux
`ifndef SMM_CFG_SVH
`define SMM_CFG_SVH

// ************************************************************
// register map
// ************************************************************
`define SMM_ADDR_W 10
`define SMM_OFS_SEL0 10'h230
`define SMM_OFS_SEL1 10'h231
`define SMM_SEL_MSB 5
`define SMM_SEL_W 6
`define SMM_SEL_RST 6'h00

// ************************************************************
// select codes
// ************************************************************
`define SMM_C_GND 6'h00
`define SMM_C_BOTH_LOCK 6'h01
`define SMM_C_IN_LOCK 6'h02
`define SMM_C_OUT_LOCK 6'h03
`define SMM_C_HOLDOVER 6'h04
`define SMM_C_HOLD_LOCK 6'h05
`define SMM_C_SEC_SEL 6'h06
`define SMM_C_PRI_OK 6'h07
`define SMM_C_SEC_OK 6'h08
`define SMM_C_TST_OK 6'h09
`define SMM_C_OSC_OK 6'h0a
`define SMM_C_FB_OK 6'h0b
`define SMM_C_OREF_OK 6'h0c
`define SMM_C_RSVD 6'h0d
`define SMM_C_REFS_OK 6'h0e
`define SMM_C_ALL_OK 6'h0f
`define SMM_C_FB_DIV 6'h10
`define SMM_C_DN_DIV 6'h11
`define SMM_C_REF_DIV 6'h12
`define SMM_C_UP_DIV 6'h13
`define SMM_C_LAST_GND 6'h17

// ************************************************************
// synchronised flag vector layout
// ************************************************************
`define SMM_NFLAG 13
`define SMM_F_IN_LOCK 0
`define SMM_F_OUT_LOCK 1
`define SMM_F_PRI_OK 2
`define SMM_F_SEC_OK 3
`define SMM_F_TST_OK 4
`define SMM_F_OSC_OK 5
`define SMM_F_FB_OK 6
`define SMM_F_OREF_OK 7
`define SMM_F_SEC_SEL 8
`define SMM_F_FB_CLK 9
`define SMM_F_DN 10
`define SMM_F_REF_CLK 11
`define SMM_F_UP 12

`endif

// ---- shared/smm_pkg.sv ----
// types shared by the status monitor mux
package smm_pkg;
  typedef logic [5:0] smm_sel_t;
  typedef logic [7:0] smm_byte_t;
endpackage
